// file: dv/spu_dma_partner.sv
// model of the transfer engine requesting the local store
`timescale 1ns/1ps
module spu_dma_partner (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic go_i,
    input wire logic gnt_i,
    output logic req_o,
    output logic [17:0] addr_o,
    output logic [1023:0] wdata_o
);
    logic [3:0] gap_reg;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            req_o <= 1'b0;
            gap_reg <= 4'h0;
            addr_o <= 18'h00080;
            wdata_o <= {64{16'h5aa5}};
        end else if (req_o && gnt_i) begin
            req_o <= 1'b0;
            gap_reg <= 4'h8;
            wdata_o <= ~wdata_o;
        end else if (gap_reg != 4'h0) begin
            gap_reg <= gap_reg - 4'h1;
        end else if (go_i) begin
            req_o <= 1'b1;
            addr_o <= addr_o + 18'h00080;
        end
    end
endmodule // spu_dma_partner

// file: dv/spu_issue_and_store_arbiter_sva.sv
// checker: assertions on the issue and arbiter ports
`timescale 1ns/1ps
module spu_issue_and_store_arbiter_sva (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic mispredict_i,
    input spu_issue_pkg::issue_type even_issue_o,
    input spu_issue_pkg::issue_type odd_issue_o,
    input wire logic issue_stalled_o,
    input spu_issue_pkg::ls_req_type ls_req_i,
    input wire logic dma_gnt_o,
    input wire logic ls_gnt_o,
    input wire logic fetch_gnt_o,
    input spu_issue_pkg::ls_grant_type ls_owner_o,
    input wire logic ls_port_en_o,
    input wire logic [7:0] ls_bank_en_o
);
    import spu_issue_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_idle;
        !even_issue_o.valid && !odd_issue_o.valid;
    endsequence
    a_one_grant: assert property ($onehot0({dma_gnt_o, ls_gnt_o, fetch_gnt_o}))
        else $error("more than one grant");
    a_fetch_last: assert property (fetch_gnt_o |-> !dma_gnt_o && !ls_gnt_o
        && !(ls_req_i.valid && ls_req_i.addr[3:0] == 4'h0))
        else $error("fetch granted over a load or store");
    a_ls_aligned: assert property (ls_gnt_o |-> ls_req_i.addr[3:0] == 4'h0)
        else $error("misaligned access granted");
    a_dma_gap: assert property (dma_gnt_o |=> !dma_gnt_o [*7])
        else $error("transfer grants too close");
    a_dma_port: assert property (dma_gnt_o |=> ls_port_en_o && ls_owner_o == grant_dma
        && ls_bank_en_o == 8'hff)
        else $error("transfer port command wrong");
    a_ls_bank: assert property (ls_gnt_o |=> ls_owner_o == grant_load_store
        && ls_bank_en_o == (8'h01 << $past(ls_req_i.addr[6:4])))
        else $error("load store bank wrong");
    a_fetch_banks: assert property (fetch_gnt_o |=> ls_owner_o == grant_fetch
        && ls_bank_en_o == 8'hff)
        else $error("fetch not on all banks");
    a_double_stall: assert property (even_issue_o.valid && even_issue_o.cls == double_float_class
        |-> !odd_issue_o.valid ##1 s_idle [*6])
        else $error("issue beside or after double");
    a_even_route: assert property (even_issue_o.valid |-> even_issue_o.cls inside
        {single_float_class, double_float_class, float_int_class, simple_integer_class,
        word_rotate_class, byte_op_class, execute_noop})
        else $error("odd class on even pipe");
    a_odd_route: assert property (odd_issue_o.valid |-> odd_issue_o.cls inside
        {load_store_class, jump_hint_class, jump_resolve_class, port_access_class,
        byte_permute_class, load_noop})
        else $error("even class on odd pipe");
    a_double_lat: assert property (even_issue_o.valid && even_issue_o.cls == double_float_class
        |-> even_issue_o.latency == LAT_DOUBLE_FLOAT)
        else $error("double latency wrong");
    a_refetch_hold: assert property (mispredict_i |=> issue_stalled_o [*8])
        else $error("no stall after mispredict");
endmodule // spu_issue_and_store_arbiter_sva
bind spu_issue_and_store_arbiter spu_issue_and_store_arbiter_sva u_sva (.*);

// file: dv/test_spu_issue_and_store_arbiter.sv
// testbench for the issue logic and local store arbiter
`timescale 1ns/1ps
module test_spu_issue_and_store_arbiter;
    import spu_issue_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    slot_type g1 = '0;
    slot_type g2 = '0;
    logic r1 = 1'b1, r2 = 1'b1, mis = 1'b0, dgo = 1'b0, freq = 1'b0;
    fetch_kind_type fk = fetch_flush;
    ls_req_type lsr = '0;
    logic gr, st, flt, dreq, dg, lg, fg, pen;
    logic [17:0] dad;
    logic [1023:0] dwd;
    issue_type ev, od;
    ls_grant_type own;
    logic [7:0] ben;
    logic pwr;
    logic [17:0] pad;
    logic [1023:0] pwd;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    spu_dma_partner u_dma (.clk_i(clk), .rstn_i(rstn), .go_i(dgo), .gnt_i(dg),
        .req_o(dreq), .addr_o(dad), .wdata_o(dwd));
    spu_issue_and_store_arbiter u_dut (.core_clk_i(clk), .rstn_i(rstn),
        .group_first_i(g1), .group_second_i(g2), .group_ready_o(gr),
        .first_operands_ready_i(r1), .second_operands_ready_i(r2),
        .first_conflict_i(1'b0), .second_conflict_i(1'b0), .ecc_busy_i(1'b0),
        .mispredict_i(mis), .even_issue_o(ev), .odd_issue_o(od), .issue_stalled_o(st),
        .dma_req_i(dreq), .dma_write_i(1'b1), .dma_addr_i(dad), .dma_wdata_i(dwd),
        .ls_req_i(lsr), .ls_align_fault_o(flt), .fetch_req_i(freq), .fetch_kind_i(fk),
        .fetch_addr_i(18'h00100), .dma_gnt_o(dg), .ls_gnt_o(lg), .fetch_gnt_o(fg),
        .ls_owner_o(own), .ls_port_en_o(pen), .ls_port_write_o(pwr), .ls_port_addr_o(pad),
        .ls_bank_en_o(ben), .ls_port_wdata_o(pwd));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic t_arb();
        @(posedge clk) dgo <= 1'b1;
        @(posedge clk) dgo <= 1'b0;
        lsr <= '{1'b1, 1'b0, 18'h00030, '0};
        freq <= 1'b1;
        #1 chk(dg === 1'b1 && lg === 1'b0 && fg === 1'b0, "transfer not first");
        @(posedge clk) #1 chk(lg === 1'b1 && own === grant_dma && ben === 8'hff, "ls second");
        chk(pwr === 1'b1 && pad === 18'h00100 && pwd === {64{16'h5aa5}}, "transfer port");
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) lsr.valid <= 1'b0;
            #1 chk(fg === 1'b1, "fetch not granted");
            chk(own === grant_load_store && ben === 8'h08 && pad === 18'h00030, "ls port");
            chk(pwr === 1'b0 && pwd === '0, "ls write data");
            @(posedge clk) fk <= fetch_kind_type'((k + 1) % 3);
            lsr.valid <= 1'b1;
            #1 chk(lg === 1'b1 && fg === 1'b0 && ben === 8'hff, "fetch over ls");
            chk(own === grant_fetch && pad === 18'h00100, "fetch line");
        end
        @(posedge clk) lsr.addr <= 18'h00034;
        freq <= 1'b0;
        #1 chk(flt === 1'b1 && lg === 1'b0 && own === grant_load_store, "misaligned");
        @(posedge clk) lsr.valid <= 1'b0;
        $display("test arbiter done");
    endtask
    task automatic t_pair(input instr_class_type c1, input instr_class_type c2, input logic v2);
        @(posedge clk) g1 <= '{1'b1, c1, 32'h11};
        g2 <= '{v2, c2, 32'h22};
        n = 0;
        #1 while (gr !== 1'b1 && n < 30) begin
            @(posedge clk) #1 n++;
        end
        chk(n < 30, "group never done");
        @(posedge clk) g1.valid <= 1'b0;
        g2.valid <= 1'b0;
    endtask
    task automatic t_issue();
        t_pair(simple_integer_class, load_store_class, 1'b1);
        #1 chk(ev.latency === LAT_SIMPLE_INTEGER && od.cls === load_store_class
            && od.latency === LAT_LOAD_STORE, "dual issue");
        fork
            t_pair(word_rotate_class, load_store_class, 1'b1);
            begin
                @(posedge clk) r2 <= 1'b0;
                @(posedge clk) #1 chk(ev.valid === 1'b1 && od.valid === 1'b0
                    && gr === 1'b0, "first alone");
                @(posedge clk) r2 <= 1'b1;
            end
        join
        #1 chk(od.valid === 1'b1 && ev.valid === 1'b0, "second late");
        t_pair(byte_op_class, load_store_class, 1'b0);
        #1 chk(ev.latency === LAT_BYTE_OP && od.valid === 1'b0, "single slot");
        t_pair(double_float_class, load_store_class, 1'b1);
        #1 chk(n == DOUBLE_STALL_CYCLES + 1 && od.valid === 1'b1 && od.cls === load_store_class
            && ev.valid === 1'b0, "double stall");
        $display("test issue done");
    endtask
    task automatic t_mis();
        @(posedge clk) mis <= 1'b1;
        @(posedge clk) mis <= 1'b0;
        n = 0;
        #1 while (st === 1'b1 && n < 40) begin
            @(posedge clk) #1 n++;
        end
        chk(n >= 17 && n <= 19, "refetch penalty");
        $display("test mispredict done");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_arb();
        t_issue();
        t_mis();
        summarize();
    end
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule // test_spu_issue_and_store_arbiter

// file: hw/spu_issue_and_store_arbiter.sv
// module: dual-pipeline in-order issue and fixed-priority local store arbiter
`timescale 1ns/1ps
module spu_issue_and_store_arbiter #(
    parameter int unsigned ADDR_W = 18
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // fetch group in
    input spu_issue_pkg::slot_type group_first_i,
    input spu_issue_pkg::slot_type group_second_i,
    output logic group_ready_o,
    // readiness from scoreboard and resources
    input wire logic first_operands_ready_i,
    input wire logic second_operands_ready_i,
    input wire logic first_conflict_i,
    input wire logic second_conflict_i,
    input wire logic ecc_busy_i,
    // branch outcome
    input wire logic mispredict_i,
    // issue out
    output spu_issue_pkg::issue_type even_issue_o,
    output spu_issue_pkg::issue_type odd_issue_o,
    output logic issue_stalled_o,
    // local store requests
    input wire logic dma_req_i,
    input wire logic dma_write_i,
    input wire logic [ADDR_W-1:0] dma_addr_i,
    input wire logic [1023:0] dma_wdata_i,
    input spu_issue_pkg::ls_req_type ls_req_i,
    output logic ls_align_fault_o,
    input wire logic fetch_req_i,
    input spu_issue_pkg::fetch_kind_type fetch_kind_i,
    input wire logic [ADDR_W-1:0] fetch_addr_i,
    // local store port
    output logic dma_gnt_o,
    output logic ls_gnt_o,
    output logic fetch_gnt_o,
    output spu_issue_pkg::ls_grant_type ls_owner_o,
    output logic ls_port_en_o,
    output logic ls_port_write_o,
    output logic [ADDR_W-1:0] ls_port_addr_o,
    output logic [7:0] ls_bank_en_o,
    output logic [1023:0] ls_port_wdata_o
);
    import spu_issue_pkg::*;

    // the port address keeps bits 6:0 below the line field
    if (ADDR_W < 8) begin : g_addr_w_low
        $error("ADDR_W too small for a line address");
    end
    // load and store addresses carry 18 bits
    if (ADDR_W > 18) begin : g_addr_w_high
        $error("ADDR_W wider than the load store address");
    end

    function automatic logic is_odd_class(input instr_class_type c);
        case (c)
            load_store_class, jump_hint_class, jump_resolve_class,
            port_access_class, byte_permute_class, load_noop: is_odd_class = 1'b1;
            default: is_odd_class = 1'b0;
        endcase
    endfunction

    function automatic logic [LAT_W-1:0] class_latency(input instr_class_type c);
        case (c)
            load_store_class: class_latency = LAT_LOAD_STORE;
            jump_hint_class: class_latency = LAT_JUMP_HINT;
            jump_resolve_class: class_latency = LAT_JUMP_RESOLVE;
            port_access_class: class_latency = LAT_PORT_ACCESS;
            single_float_class: class_latency = LAT_SINGLE_FLOAT;
            double_float_class: class_latency = LAT_DOUBLE_FLOAT;
            float_int_class: class_latency = LAT_FLOAT_INT;
            byte_permute_class: class_latency = LAT_BYTE_PERMUTE;
            simple_integer_class: class_latency = LAT_SIMPLE_INTEGER;
            word_rotate_class: class_latency = LAT_WORD_ROTATE;
            byte_op_class: class_latency = LAT_BYTE_OP;
            default: class_latency = LAT_NOOP;
        endcase
    endfunction

    function automatic issue_type make_issue(input slot_type s);
        make_issue.valid = 1'b1;
        make_issue.cls = s.cls;
        make_issue.word = s.word;
        make_issue.latency = class_latency(s.cls);
    endfunction

    function automatic logic [ADDR_W-1:0] line_addr(input logic [ADDR_W-1:0] a);
        line_addr = {a[ADDR_W-1:7], 7'h00};
    endfunction

    // local store arbiter
    logic dma_win;
    logic ls_win;
    logic fetch_win;
    logic ls_aligned;
    logic [2:0] dma_slot_reg;
    logic dma_slot_free;

    // dma may take at most one slot in eight
    assign dma_slot_free = (dma_slot_reg == 3'h0);
    assign ls_aligned = (ls_req_i.addr[3:0] == 4'h0);
    assign dma_win = dma_req_i && dma_slot_free;
    assign ls_win = ls_req_i.valid && ls_aligned && !dma_win;
    assign fetch_win = fetch_req_i && !dma_win && !ls_win;
    assign dma_gnt_o = dma_win;
    assign ls_gnt_o = ls_win;
    assign fetch_gnt_o = fetch_win;
    assign ls_align_fault_o = ls_req_i.valid && !ls_aligned;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            dma_slot_reg <= 3'h0;
        end else if (dma_win) begin
            dma_slot_reg <= DMA_GAP_CYCLES;
        end else if (dma_slot_reg != 3'h0) begin
            dma_slot_reg <= dma_slot_reg - 3'h1;
        end
    end

    // port enable and owner follow the winning requester
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ls_port_en_o <= 1'b0;
            ls_owner_o <= grant_none;
        end else begin
            ls_port_en_o <= dma_win || ls_win || fetch_win;
            if (dma_win) begin
                ls_owner_o <= grant_dma;
            end else if (ls_win) begin
                ls_owner_o <= grant_load_store;
            end else if (fetch_win) begin
                ls_owner_o <= grant_fetch;
            end else begin
                ls_owner_o <= grant_none;
            end
        end
    end

    // write strobe only for dma and load/store winners
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ls_port_write_o <= 1'b0;
        end else if (dma_win) begin
            ls_port_write_o <= dma_write_i;
        end else if (ls_win) begin
            ls_port_write_o <= ls_req_i.write;
        end else begin
            ls_port_write_o <= 1'b0;
        end
    end

    // address and write data hold their last value when idle
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ls_port_addr_o <= '0;
            ls_port_wdata_o <= '0;
        end else if (dma_win) begin
            ls_port_addr_o <= line_addr(dma_addr_i);
            ls_port_wdata_o <= dma_wdata_i;
        end else if (ls_win) begin
            ls_port_addr_o <= ls_req_i.addr[ADDR_W-1:0];
            ls_port_wdata_o <= {8{ls_req_i.wdata}};
        end else if (fetch_win) begin
            ls_port_addr_o <= line_addr(fetch_addr_i);
        end
    end

    // banks: all eight for a line, one for a quadword
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ls_bank_en_o <= 8'h00;
        end else if (dma_win) begin
            ls_bank_en_o <= 8'hff;
        end else if (ls_win) begin
            ls_bank_en_o <= 8'h01 << ls_req_i.addr[6:4];
        end else if (fetch_win) begin
            ls_bank_en_o <= 8'hff;
        end else begin
            ls_bank_en_o <= 8'h00;
        end
    end

    // issue logic
    logic [2:0] stall_cnt_reg;
    logic [4:0] refetch_cnt_reg;
    logic first_done_reg;
    logic blocked;
    logic first_pending;
    logic second_pending;
    logic first_ok;
    logic second_ok;
    logic issue_first;
    logic issue_second;
    logic first_double;
    logic second_double;

    assign blocked = (stall_cnt_reg != 3'h0) || (refetch_cnt_reg != 5'h00);
    assign first_pending = group_first_i.valid && !first_done_reg;
    assign second_pending = group_second_i.valid;
    assign first_double = group_first_i.cls == double_float_class;
    assign second_double = group_second_i.cls == double_float_class;
    assign first_ok = first_pending && first_operands_ready_i && !first_conflict_i
        && !ecc_busy_i && !blocked;
    assign second_ok = second_pending && second_operands_ready_i && !second_conflict_i
        && !ecc_busy_i && !blocked;

    always_comb begin
        issue_first = 1'b0;
        issue_second = 1'b0;
        if (mispredict_i) begin
            issue_first = 1'b0;
            issue_second = 1'b0;
        end else if (first_pending) begin
            issue_first = first_ok;
            issue_second = first_ok && second_ok && !is_odd_class(group_first_i.cls)
                && is_odd_class(group_second_i.cls) && !first_double;
        end else begin
            issue_second = second_ok;
        end
    end

    // group empties when every valid slot has issued
    assign group_ready_o = !mispredict_i
        && (!first_pending || issue_first)
        && (!second_pending || issue_second);
    assign issue_stalled_o = blocked;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || mispredict_i || group_ready_o) begin
            first_done_reg <= 1'b0;
        end else if (issue_first) begin
            first_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            stall_cnt_reg <= 3'h0;
        end else if ((issue_first && first_double) || (issue_second && !first_pending
            && second_double)) begin
            stall_cnt_reg <= DOUBLE_STALL_CYCLES;
        end else if (stall_cnt_reg != 3'h0) begin
            stall_cnt_reg <= stall_cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            refetch_cnt_reg <= 5'h00;
        end else if (mispredict_i) begin
            refetch_cnt_reg <= MISPREDICT_PENALTY;
        end else if (refetch_cnt_reg != 5'h00) begin
            refetch_cnt_reg <= refetch_cnt_reg - 5'h01;
        end
    end

    // even pipe takes an even-class instruction from either slot
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            even_issue_o <= '0;
        end else if (issue_first && !is_odd_class(group_first_i.cls)) begin
            even_issue_o <= make_issue(group_first_i);
        end else if (issue_second && !is_odd_class(group_second_i.cls)) begin
            even_issue_o <= make_issue(group_second_i);
        end else begin
            even_issue_o <= '0;
        end
    end

    // odd pipe takes an odd-class instruction from either slot
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            odd_issue_o <= '0;
        end else if (issue_second && is_odd_class(group_second_i.cls)) begin
            odd_issue_o <= make_issue(group_second_i);
        end else if (issue_first && is_odd_class(group_first_i.cls)) begin
            odd_issue_o <= make_issue(group_first_i);
        end else begin
            odd_issue_o <= '0;
        end
    end

endmodule // spu_issue_and_store_arbiter

// file: hw/spu_issue_pkg.sv
// package: constants and types for the issue and local store arbiter block
package spu_issue_pkg;

    // instruction classes
    typedef enum logic [3:0] {
        load_store_class = 4'h0,
        jump_hint_class = 4'h1,
        jump_resolve_class = 4'h2,
        port_access_class = 4'h3,
        single_float_class = 4'h4,
        double_float_class = 4'h5,
        float_int_class = 4'h6,
        byte_permute_class = 4'h7,
        simple_integer_class = 4'h8,
        word_rotate_class = 4'h9,
        byte_op_class = 4'ha,
        execute_noop = 4'hb,
        load_noop = 4'hc
    } instr_class_type;

    // local store requesters
    typedef enum logic [1:0] {
        grant_none = 2'h0,
        grant_dma = 2'h1,
        grant_load_store = 2'h2,
        grant_fetch = 2'h3
    } ls_grant_type;

    // fetch kinds
    typedef enum logic [1:0] {
        fetch_flush = 2'h0,
        fetch_inline = 2'h1,
        fetch_hint = 2'h2
    } fetch_kind_type;

    localparam int unsigned QUAD_BYTES = 16;
    localparam int unsigned LINE_BYTES = 128;
    localparam int unsigned FETCH_INSTRS = 32;
    localparam int unsigned LAT_W = 5;

    localparam logic [LAT_W-1:0] LAT_LOAD_STORE = 5'h06;
    localparam logic [LAT_W-1:0] LAT_JUMP_HINT = 5'h0f;
    localparam logic [LAT_W-1:0] LAT_JUMP_RESOLVE = 5'h04;
    localparam logic [LAT_W-1:0] LAT_PORT_ACCESS = 5'h06;
    localparam logic [LAT_W-1:0] LAT_SINGLE_FLOAT = 5'h06;
    localparam logic [LAT_W-1:0] LAT_DOUBLE_FLOAT = 5'h0d;
    localparam logic [LAT_W-1:0] LAT_FLOAT_INT = 5'h07;
    localparam logic [LAT_W-1:0] LAT_BYTE_PERMUTE = 5'h04;
    localparam logic [LAT_W-1:0] LAT_SIMPLE_INTEGER = 5'h02;
    localparam logic [LAT_W-1:0] LAT_WORD_ROTATE = 5'h04;
    localparam logic [LAT_W-1:0] LAT_BYTE_OP = 5'h04;
    localparam logic [LAT_W-1:0] LAT_NOOP = 5'h00;

    localparam logic [2:0] DOUBLE_STALL_CYCLES = 3'h6;
    localparam logic [2:0] DMA_GAP_CYCLES = 3'h7;
    localparam logic [4:0] MISPREDICT_PENALTY = 5'h12;

    // one instruction slot of a fetch group
    typedef struct packed {
        logic valid;
        instr_class_type cls;
        logic [31:0] word;
    } slot_type;

    // one issued instruction
    typedef struct packed {
        logic valid;
        instr_class_type cls;
        logic [31:0] word;
        logic [LAT_W-1:0] latency;
    } issue_type;

    // core load or store request
    typedef struct packed {
        logic valid;
        logic write;
        logic [17:0] addr;
        logic [127:0] wdata;
    } ls_req_type;

endpackage
